//--- src/sas_pkg.sv
// Purpose: constants and types shared by the converter sequencer files
// Assumes: 8-bit register port, system clock 25 MHz
// Notes: offsets are the printed register addresses
package sas_pkg;
  localparam logic [7:0] SAS_OFS_CONFIG = 8'hA9;
  localparam logic [7:0] SAS_OFS_AMP = 8'hB9;
  localparam logic [7:0] SAS_OFS_RES_LO = 8'hBA;
  localparam logic [7:0] SAS_OFS_RES_HI = 8'hBB;
  localparam logic [7:0] SAS_OFS_CTRL = 8'hCE;
  localparam logic [7:0] SAS_RST_CONFIG = 8'h00;
  localparam logic [7:0] SAS_RST_AMP = 8'h00;
  localparam logic [7:0] SAS_RST_CTRL = 8'h00;
  // config fields
  localparam int SAS_CFG_PWR = 7;
  localparam int SAS_CFG_IRQE = 6;
  localparam int SAS_CFG_JUST = 5;
  localparam int SAS_CFG_TEMP = 4;
  localparam int SAS_CFG_VDIV = 3;
  localparam int SAS_CFG_DIV_LSB = 0;
  // control fields
  localparam int SAS_CTL_AVG_LSB = 5;
  localparam int SAS_CTL_CH_LSB = 2;
  localparam int SAS_CTL_FLAG = 1;
  localparam int SAS_CTL_TRIG = 0;
  // amplifier fields
  localparam int SAS_AMP_EN = 7;
  localparam int SAS_AMP_REF = 6;
  localparam int SAS_AMP_BIAS = 5;
  localparam int SAS_AMP_GND = 2;
  localparam int SAS_AMP_GAIN_LSB = 0;
  // conversion timing in converter clocks
  localparam logic [5:0] SAS_CONV_LAST = 6'h3F;
  localparam logic [3:0] SAS_SUB_LAST = 4'hF;
  localparam int SAS_CHAN_COUNT = 8;
  localparam logic [2:0] SAS_CHAN_FIRST_RSVD = 3'h6;
  localparam int SAS_POWER_UP_US = 20;
  localparam int SAS_CLK_MHZ = 25;
  localparam int SAS_POWER_UP_CYC = SAS_POWER_UP_US * SAS_CLK_MHZ;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_CONV = 2'b01,
    SAS_STORE = 2'b11
  } sas_state_t;
endpackage : sas_pkg

//--- src/sas_core_if.sv
// Purpose: link between sequencer and its clock divider and SAR step engine
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface sas_core_if;
  logic run;
  logic [2:0] div_sel;
  logic conv_tick;
  logic start;
  logic busy;
  logic done;
  logic [11:0] sample;
  logic [11:0] result;
  logic cmp_in;
  modport seq(output run, output div_sel, input conv_tick, output start, input busy,
    input done, input result);
  modport clk_div(input run, input div_sel, output conv_tick);
  modport sar(input run, input conv_tick, input start, output busy, output done,
    output result, input cmp_in, output sample);
  modport ana(input sample, output cmp_in);
endinterface : sas_core_if
`default_nettype wire

//--- src/sas_clk_div.sv
// Purpose: converter clock tick generator
// Assumes: divider held cleared while converter powered down
// Notes: tick is one system clock wide, once per converter period
`timescale 1ns/1ps
`default_nettype none
module sas_clk_div
  import sas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // sequencer side
  sas_core_if.clk_div cif
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] limit;

  always_comb begin
    limit = 8'(({1'b0, 8'hFF} >> (3'h7 - cif.div_sel)));
    next_count = count + 8'h01;
    // a smaller divider written mid-count must not wrap through 255
    if (!cif.run || count >= limit) begin
      next_count = 8'h00;
    end
  end

  // period is 2^(div+1) system clocks
  assign cif.conv_tick = cif.run && (count == limit);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end
endmodule : sas_clk_div
`default_nettype wire

//--- src/sas_sar_engine.sv
// Purpose: one 64-clock SAR conversion in four 16-clock sub-conversions
// Assumes: comparator answers within one converter clock
// Notes: each sub-conversion resolves 12 bits, result is the average of the four
`timescale 1ns/1ps
`default_nettype none
module sas_sar_engine
  import sas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // sequencer side
  sas_core_if.sar cif
);
  logic [5:0] step;
  logic [5:0] next_step;
  logic active;
  logic next_active;
  logic [11:0] trial;
  logic [11:0] next_trial;
  logic [13:0] acc;
  logic [13:0] next_acc;
  logic [11:0] res;
  logic [11:0] next_res;
  logic fin;
  logic next_fin;
  logic [3:0] sub;
  logic [3:0] bitn;

  assign sub = step[3:0];
  assign bitn = 4'hB - sub;

  always_comb begin
    next_step = step;
    next_active = active;
    next_trial = trial;
    next_acc = acc;
    next_res = res;
    next_fin = 1'b0;
    if (cif.start && !active) begin
      next_active = 1'b1;
      next_step = 6'h00;
      next_acc = 14'h0000;
      next_trial = 12'h800;
    end else if (active && cif.conv_tick) begin
      // steps 0..11 decide bits, 12..15 settle
      if (sub < 4'hC) begin
        if (!cif.cmp_in) begin
          next_trial[bitn] = 1'b0;
        end
        if (sub != 4'hB) begin
          next_trial[bitn - 4'h1] = 1'b1;
        end
      end
      if (sub == SAS_SUB_LAST) begin
        next_acc = acc + {2'b00, trial};
        next_trial = 12'h800;
      end
      next_step = step + 6'h01;
      if (step == SAS_CONV_LAST) begin
        next_active = 1'b0;
        next_fin = 1'b1;
        next_res = 12'((acc + {2'b00, trial}) >> 2);
      end
    end
    // power-down abandons a conversion in flight
    if (!cif.run) begin
      next_active = 1'b0;
      next_step = 6'h00;
      next_fin = 1'b0;
    end
  end

  assign cif.busy = active;
  assign cif.done = fin;
  assign cif.result = res;
  assign cif.sample = trial;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step <= 6'h00;
      active <= 1'b0;
      trial <= 12'h000;
      acc <= 14'h0000;
      res <= 12'h000;
      fin <= 1'b0;
    end else begin
      step <= next_step;
      active <= next_active;
      trial <= next_trial;
      acc <= next_acc;
      res <= next_res;
      fin <= next_fin;
    end
  end
endmodule : sas_sar_engine
`default_nettype wire

//--- src/sas_sequencer.sv
// Purpose: register file and conversion sequencing of the 12-bit SAR converter
// Assumes: register port strobes one cycle wide, never both at once
// Notes: read data valid the cycle after the read strobe
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
  import sas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog core
  input wire logic cmp_out,
  output logic [11:0] dac_code,
  output logic converter_power_on,
  output logic [7:0] channel_route,
  output logic thermal_sensor_enable,
  output logic supply_divider_enable,
  output logic [2:0] test_mode,
  output logic amp_enable,
  output logic fullscale_ref_select,
  output logic amp_bias_ref_select,
  output logic amp_input_ground,
  output logic [1:0] amp_gain,
  // interrupt request
  output logic done_irq
);
  sas_core_if cif();

  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic [7:0] amp;
  logic [7:0] next_amp;
  logic [2:0] avg_sel;
  logic [2:0] next_avg_sel;
  logic [2:0] chan_sel;
  logic [2:0] next_chan_sel;
  logic trig;
  logic next_trig;
  logic flag;
  logic next_flag;
  logic [11:0] result;
  logic [11:0] next_result;
  logic [3:0] avg_cnt;
  logic [3:0] next_avg_cnt;
  logic [14:0] avg_acc;
  logic [14:0] next_avg_acc;
  logic [11:0] pend;
  logic [11:0] next_pend;
  logic pend_valid;
  logic next_pend_valid;
  sas_state_t state;
  sas_state_t next_state;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [3:0] avg_total;
  logic [11:0] avg_value;
  logic wr_cfg;
  logic wr_amp;
  logic wr_ctl;
  logic rd_lo;
  logic irq;
  logic next_irq;

  sas_clk_div u_clk_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cif(cif.clk_div)
  );

  sas_sar_engine u_sar (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cif(cif.sar)
  );

  assign cif.cmp_in = cmp_out;
  assign dac_code = cif.sample;
  assign cif.run = cfg[SAS_CFG_PWR];
  assign cif.div_sel = cfg[SAS_CFG_DIV_LSB +: 3];
  assign cif.start = (state == SAS_CONV) && !cif.busy && !cif.done;

  // register port decode
  always_comb begin
    wr_cfg = 1'b0;
    wr_amp = 1'b0;
    wr_ctl = 1'b0;
    if (reg_wr && reg_addr == SAS_OFS_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == SAS_OFS_AMP) begin
      wr_amp = 1'b1;
    end else if (reg_wr && reg_addr == SAS_OFS_CTRL) begin
      wr_ctl = 1'b1;
    end
  end
  assign rd_lo = reg_rd && (reg_addr == SAS_OFS_RES_LO);

  // result formatting
  always_comb begin
    if (cfg[SAS_CFG_JUST]) begin
      res_hi = result[11:4];
      res_lo = {result[3:0], 4'h0};
    end else begin
      res_hi = {4'h0, result[11:8]};
      res_lo = result[7:0];
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == SAS_OFS_CONFIG) begin
        next_rdata = cfg;
      end else if (reg_addr == SAS_OFS_AMP) begin
        next_rdata = 8'h00;
      end else if (reg_addr == SAS_OFS_RES_LO) begin
        next_rdata = res_lo;
      end else if (reg_addr == SAS_OFS_RES_HI) begin
        next_rdata = res_hi;
      end else if (reg_addr == SAS_OFS_CTRL) begin
        next_rdata = {avg_sel, chan_sel, flag, trig};
      end
    end
  end

  // averaging count: 1, 2, 4 or 8; test codes convert once
  always_comb begin
    if (avg_sel[2]) begin
      avg_total = 4'h1;
    end else begin
      avg_total = 4'(4'h1 << avg_sel[1:0]);
    end
    avg_value = 12'((avg_acc + {3'b000, cif.result}) >> (avg_sel[2] ? 2'd0 : avg_sel[1:0]));
  end

  // configuration and control
  always_comb begin
    next_cfg = cfg;
    next_amp = amp;
    next_avg_sel = avg_sel;
    next_chan_sel = chan_sel;
    next_trig = trig;
    if (wr_cfg) begin
      next_cfg = reg_wdata;
    end
    if (wr_amp) begin
      next_amp = reg_wdata & 8'hE7;
    end
    if (wr_ctl) begin
      next_avg_sel = reg_wdata[SAS_CTL_AVG_LSB +: 3];
      next_chan_sel = reg_wdata[SAS_CTL_CH_LSB +: 3];
      if (reg_wdata[SAS_CTL_TRIG] && next_cfg[SAS_CFG_PWR]) begin
        next_trig = 1'b1;
      end
    end
    if (state == SAS_STORE) begin
      next_trig = 1'b0;
    end
    if (!next_cfg[SAS_CFG_PWR]) begin
      next_trig = 1'b0;
    end
  end

  // conversion sequence
  always_comb begin
    next_state = state;
    next_avg_cnt = avg_cnt;
    next_avg_acc = avg_acc;
    next_pend = pend;
    next_pend_valid = pend_valid;
    next_result = result;
    next_flag = flag;
    next_irq = 1'b0;
    if (rd_lo) begin
      next_flag = 1'b0;
    end
    case (state)
      SAS_IDLE: begin
        next_avg_cnt = 4'h0;
        next_avg_acc = 15'h0000;
        if (trig && cfg[SAS_CFG_PWR]) begin
          next_state = SAS_CONV;
        end
      end
      SAS_CONV: begin
        if (cif.done) begin
          // the selected channel finishes its averaging before the result is stored
          if (avg_cnt + 4'h1 == avg_total) begin
            next_pend = avg_value;
            next_pend_valid = 1'b1;
            next_state = SAS_STORE;
          end else begin
            next_avg_cnt = avg_cnt + 4'h1;
            next_avg_acc = avg_acc + {3'b000, cif.result};
          end
        end
      end
      SAS_STORE: begin
        next_state = SAS_IDLE;
      end
      default: begin
        next_state = SAS_IDLE;
      end
    endcase
    if (pend_valid && !flag) begin
      next_result = pend;
      next_pend_valid = 1'b0;
      next_flag = 1'b1;
      next_irq = cfg[SAS_CFG_IRQE];
    end
    if (!cfg[SAS_CFG_PWR]) begin
      next_state = SAS_IDLE;
    end
  end

  // analog control outputs
  always_comb begin
    channel_route = 8'h00;
    if (chan_sel < SAS_CHAN_FIRST_RSVD) begin
      channel_route[chan_sel] = cfg[SAS_CFG_PWR];
    end
  end
  assign converter_power_on = cfg[SAS_CFG_PWR];
  assign thermal_sensor_enable = cfg[SAS_CFG_TEMP];
  assign supply_divider_enable = cfg[SAS_CFG_VDIV];
  assign test_mode = avg_sel[2] ? avg_sel : 3'h0;
  assign amp_enable = amp[SAS_AMP_EN];
  assign fullscale_ref_select = amp[SAS_AMP_REF];
  assign amp_bias_ref_select = amp[SAS_AMP_BIAS];
  assign amp_input_ground = amp[SAS_AMP_GND];
  assign amp_gain = amp[SAS_AMP_GAIN_LSB +: 2];
  assign reg_rdata = rdata;
  assign done_irq = irq;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg <= SAS_RST_CONFIG;
      amp <= SAS_RST_AMP;
      avg_sel <= 3'h0;
      chan_sel <= 3'h0;
      trig <= 1'b0;
      flag <= 1'b0;
      result <= 12'h000;
      avg_cnt <= 4'h0;
      avg_acc <= 15'h0000;
      pend <= 12'h000;
      pend_valid <= 1'b0;
      state <= SAS_IDLE;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      amp <= next_amp;
      avg_sel <= next_avg_sel;
      chan_sel <= next_chan_sel;
      trig <= next_trig;
      flag <= next_flag;
      result <= next_result;
      avg_cnt <= next_avg_cnt;
      avg_acc <= next_avg_acc;
      pend <= next_pend;
      pend_valid <= next_pend_valid;
      state <= next_state;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end
endmodule : sas_sequencer
`default_nettype wire

//--- dv/sas_checker.sv
// Purpose: port assertions for the converter sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: irq enable is tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module sas_checker
  import sas_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // core controls
  input wire logic converter_power_on,
  input wire logic [7:0] channel_route,
  input wire logic supply_divider_enable,
  input wire logic [2:0] test_mode,
  input wire logic amp_enable,
  input wire logic fullscale_ref_select,
  input wire logic amp_bias_ref_select,
  input wire logic amp_input_ground,
  input wire logic [1:0] amp_gain,
  input wire logic done_irq
);
  logic irq_en;
  logic [7:0] wd_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    wd_q <= reg_wdata;
    if (sys_rst) irq_en <= 1'b0;
    else if (reg_wr && reg_addr == SAS_OFS_CONFIG) irq_en <= reg_wdata[SAS_CFG_IRQE];
  end
  a_route_powered: assert property (!converter_power_on |-> channel_route == 8'h00)
    else $error("channel routed while powered down");
  a_route_onehot: assert property ($onehot0(channel_route))
    else $error("more than one channel routed");
  a_cfg_follows: assert property (reg_wr && reg_addr == SAS_OFS_CONFIG |=>
    converter_power_on == wd_q[7] && supply_divider_enable == wd_q[3])
    else $error("config outputs do not follow write");
  a_amp_follows: assert property (
    reg_wr && reg_addr == SAS_OFS_AMP |=>
    {amp_enable, fullscale_ref_select, amp_bias_ref_select, amp_input_ground, amp_gain}
    == {wd_q[7:5], wd_q[2:0]})
    else $error("amplifier outputs do not follow write");
  a_test_mode: assert property (reg_wr && reg_addr == SAS_OFS_CTRL |=>
    test_mode == (wd_q[7] ? wd_q[7:5] : 3'h0))
    else $error("test mode wrong");
  a_irq_enable: assert property (done_irq |-> irq_en)
    else $error("request while disabled");
  a_irq_spacing: assert property (done_irq |=> !done_irq [*8])
    else $error("requests too close");
  a_trig_off: assert property (reg_rd && reg_addr == SAS_OFS_CTRL
    && !converter_power_on |=> reg_rdata[0] == 1'b0)
    else $error("trigger set while powered down");
endmodule : sas_checker
`default_nettype wire

//--- dv/sas_analog_model.sv
// Purpose: analog core stand-in: input mux, amplifier ground, comparator
// Assumes: comparator settles within one system clock
// Notes: with no route the comparator toggles, it carries no meaning
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
  // clock
  input wire logic clk_sys,
  // core controls
  input wire logic [7:0] channel_route,
  input wire logic amp_input_ground,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] pin_level,
  // comparator
  output logic cmp_out
);
  logic tog = 1'b0;
  logic [11:0] lvl;
  always @(posedge clk_sys) tog <= !tog;
  always_comb begin
    lvl = 12'h000;
    for (int k = 0; k < 6; k++) begin
      if (channel_route[k]) lvl = pin_level + 12'(k * 256);
    end
    if (channel_route[1] && amp_input_ground) lvl = 12'h000;
  end
  assign cmp_out = (channel_route == 8'h00) ? tog : (lvl >= dac_code);
endmodule : sas_analog_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: register strobes one cycle, read data the cycle after
// Notes: channel k input level is pin_level plus k*256
`timescale 1ns/1ps
`default_nettype none
module tb
  import sas_pkg::*;
;
  logic clk_sys, sys_rst, reg_wr, reg_rd, cmp_out, converter_power_on, done_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, channel_route;
  logic [11:0] dac_code, pin_level;
  logic thermal_sensor_enable, supply_divider_enable, amp_enable, fullscale_ref_select;
  logic amp_bias_ref_select, amp_input_ground;
  logic [2:0] test_mode;
  logic [1:0] amp_gain;
  int mismatches, total_checks, cyc, irqs;
  sas_sequencer sas_sequencer_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cmp_out, .dac_code, .converter_power_on, .channel_route,
    .thermal_sensor_enable, .supply_divider_enable, .test_mode, .amp_enable,
    .fullscale_ref_select, .amp_bias_ref_select, .amp_input_ground, .amp_gain, .done_irq);
  sas_analog_model sas_analog_model_inst (.clk_sys, .channel_route, .amp_input_ground,
    .dac_code, .pin_level, .cmp_out);
  // request pulses seen, sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (done_irq === 1'b1) begin
      irqs++;
    end
  end
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(nm, reg_rdata, e);
    @(posedge clk_sys);
  endtask : rchk
  task automatic wait_irq();
    cyc = 0;
    #1;
    while (done_irq !== 1'b1 && cyc < 40000) begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    @(posedge clk_sys);
  endtask : wait_irq
  task automatic conv(input logic [2:0] dv, input logic [1:0] av, input logic [2:0] ch,
      input logic js, input logic rt, input logic [11:0] e);
    int p;
    int b;
    logic in_time;
    p = 2 << dv;
    b = (64 << av) * p;
    wr(SAS_OFS_CONFIG, {3'b110 | {2'b00, js}, 2'b00, dv});
    wr(SAS_OFS_CTRL, {1'b0, av, ch, 2'b01});
    if (rt) begin
      repeat (40) @(posedge clk_sys);
      wr(SAS_OFS_CTRL, {1'b0, av, ch, 2'b01});
      b = b - 42;
    end
    wait_irq();
    in_time = cyc >= b - p && cyc <= b + (p + 4) * (1 << av) + 8;
    check("time", 12'(in_time), 12'h001);
    rchk("done", SAS_OFS_CTRL, {1'b0, av, ch, 2'b10});
    rchk("high", SAS_OFS_RES_HI, js ? e[11:4] : {4'h0, e[11:8]});
    rchk("low", SAS_OFS_RES_LO, js ? {e[3:0], 4'h0} : e[7:0]);
    rchk("clear", SAS_OFS_CTRL, {1'b0, av, ch, 2'b00});
  endtask : conv
  task automatic t_idle();
    rchk("cfg", SAS_OFS_CONFIG, 8'h00);
    rchk("amp", SAS_OFS_AMP, 8'h00);
    rchk("gap", 8'h00, 8'h00);
    check("gain", amp_gain, 12'h000);
    wr(SAS_OFS_CONFIG, 8'h18);
    check("divnet", {supply_divider_enable, thermal_sensor_enable}, 12'h003);
    wr(SAS_OFS_CTRL, 8'h03);
    repeat (300) @(posedge clk_sys);
    rchk("trig off", SAS_OFS_CTRL, 8'h00);
    check("pwr", {converter_power_on, channel_route}, 12'h000);
  endtask : t_idle
  task automatic t_route();
    wr(SAS_OFS_CONFIG, 8'h80);
    repeat (500) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      wr(SAS_OFS_CTRL, {3'(i), 3'(i), 2'b00});
      check("route", channel_route, i < 6 ? 12'(1 << i) : 12'h000);
      check("test", test_mode, i > 3 ? 12'(i) : 12'h000);
    end
    wr(SAS_OFS_AMP, 8'hE7);
    check("amp", {amp_enable, fullscale_ref_select, amp_bias_ref_select, amp_input_ground,
      amp_gain}, 12'h03F);
    wr(SAS_OFS_AMP, 8'h00);
  endtask : t_route
  task automatic t_hold();
    int n0;
    wr(SAS_OFS_CONFIG, 8'hE0);
    wr(SAS_OFS_CTRL, 8'h01);
    repeat (40) @(posedge clk_sys);
    wr(SAS_OFS_CONFIG, 8'h60);
    rchk("abort", SAS_OFS_CTRL, 8'h00);
    wr(SAS_OFS_CONFIG, 8'hE0);
    repeat (500) @(posedge clk_sys);
    wr(SAS_OFS_CTRL, 8'h01);
    wait_irq();
    check("restart", 12'(cyc >= 126 && cyc <= 140), 12'h001);
    wr(SAS_OFS_CONFIG, 8'hA0);
    n0 = irqs;
    pin_level <= 12'h5A6;
    wr(SAS_OFS_CTRL, 8'h01);
    repeat (300) @(posedge clk_sys);
    rchk("old hi", SAS_OFS_RES_HI, 8'h12);
    rchk("old lo", SAS_OFS_RES_LO, 8'h30);
    rchk("flag", SAS_OFS_CTRL, 8'h02);
    rchk("new hi", SAS_OFS_RES_HI, 8'h5A);
    rchk("new lo", SAS_OFS_RES_LO, 8'h60);
    check("no irq", 12'(irqs - n0), 12'h000);
  endtask : t_hold
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin_level = 12'h123;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_idle();
    t_route();
    for (int i = 0; i < 8; i++) conv(3'(i), 2'h0, 3'h0, 1'b0, 1'b0, 12'h123);
    for (int i = 0; i < 4; i++) conv(3'h0, 2'(i), 3'h5, 1'b1, i == 1, 12'h623);
    wr(SAS_OFS_AMP, 8'h84);
    repeat (250) @(posedge clk_sys);
    conv(3'h0, 2'h0, 3'h1, 1'b1, 1'b0, 12'h000);
    t_hold();
    final_report();
  end
  initial begin
    #3000000;
    mismatches++;
    final_report();
  end
endmodule : tb
bind sas_sequencer sas_checker sas_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .converter_power_on(converter_power_on),
  .channel_route(channel_route), .supply_divider_enable(supply_divider_enable),
  .test_mode(test_mode), .amp_enable(amp_enable), .fullscale_ref_select(fullscale_ref_select),
  .amp_bias_ref_select(amp_bias_ref_select), .amp_input_ground(amp_input_ground),
  .amp_gain(amp_gain), .done_irq(done_irq));
`default_nettype wire
